// ---- design/fault_recovery_unit.sv ----
// Fault recovery unit: trip clearing, delayed restart and retry accounting for a motor drive.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Recovery runs only while recovery_enable is set; clearing it returns the unit to idle.
// - With policy 0 the trip is cleared once all sources are inactive and the motor never restarts.
// - With resume_if_was_running a restart follows only if the motor ran at the trip and run is on.
// - With launch_on_run_request the motor is started after the trip whenever run is requested.
// - A programmable retry_limit bounds attempts; when used up the unit disables itself.
// - Only trips whose cause is selected in fault_select_mask are acted on; others leave it idle.
// - The first attempt, when retries_left equals retry_limit, waits first_wait_seconds.
// - Later attempts, when retries_left differs from retry_limit, wait later_wait_seconds.
// - The restart delay starts only when every trip source has become inactive.
// - When only clearing and not restarting, both delays are skipped.
// - The number of restart attempts made is counted for monitoring.
// - retries_left reloads from retry_limit after 5 minutes trip-free or a manual trip reset.
// - Under resume_if_was_running, losing run at any time after the trip means clear only.
// - Each attempt decrements retries_left; a selected trip at zero self-disables the unit unless the policy is clear-only.
module fault_recovery_unit #(
	parameter int TICK_CYCLES = recovery_pkg::TICK_CYCLES
) (
	input wire logic clk, // System clock, 250 MHz.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic [recovery_pkg::ADDR_W-1:0] reg_addr, // Register byte address.
	input wire logic [recovery_pkg::DATA_W-1:0] reg_wdata, // Register write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output logic [recovery_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after reg_rd.
	input wire logic trip_event, // One-cycle pulse when the drive trips.
	input wire logic [recovery_pkg::CAUSE_W-1:0] trip_cause, // Cause bits beside trip_event.
	input wire logic [recovery_pkg::SRC_W-1:0] trip_sources, // Trip sources still active.
	input wire logic motor_running, // Motor was running, sampled at trip_event.
	input wire logic run_request, // Run request from sequencing.
	input wire logic manual_trip_reset, // Pulse: trip reset by other means succeeded.
	output logic trip_clear, // Pulse: reset the trip.
	output logic motor_start, // Pulse: restart the motor.
	output logic recovery_active, // Unit is handling a trip.
	output logic restart_pending, // Restart delay is running.
	output logic self_disabled, // Retries exhausted.
	output logic irq // Level interrupt.
);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	recovery_pkg::settings_t cfg_reg;
	recovery_pkg::bus_req_t req;
	recovery_pkg::unit_state_t state_reg;
	logic [recovery_pkg::EV_W-1:0] irq_stat_reg;
	logic [recovery_pkg::EV_W-1:0] irq_mask_reg;
	logic [recovery_pkg::EV_W-1:0] ev_set;
	logic [recovery_pkg::RETRY_W-1:0] retries_left_reg;
	logic [recovery_pkg::ATT_W-1:0] attempts_reg;
	logic [recovery_pkg::SEC_W-1:0] timer_reg;
	logic [recovery_pkg::DATA_W-1:0] rdata_next;
	logic enable_prev_reg;
	logic was_running_reg;
	logic run_lost_reg;

	assign req.addr = reg_addr;
	assign req.wdata = reg_wdata;
	assign req.wr = reg_wr;
	assign req.rd = reg_rd;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cfg_reg.recovery_enable <= 1'b0;
			cfg_reg.recovery_policy <= recovery_pkg::CLEAR_ONLY_POLICY;
			cfg_reg.retry_limit <= recovery_pkg::LIMIT_RST;
			cfg_reg.fault_select_mask <= recovery_pkg::MASK_RST;
			cfg_reg.first_wait_seconds <= recovery_pkg::FIRST_RST;
			cfg_reg.later_wait_seconds <= recovery_pkg::LATER_RST;
		end
		else if (req.wr)
		begin
			unique case (req.addr)
				recovery_pkg::CTRL_OFS:
				begin
					cfg_reg.recovery_enable <= req.wdata[recovery_pkg::CTRL_EN_BIT];
					cfg_reg.recovery_policy <= req.wdata[recovery_pkg::CTRL_POL_LSB +: 2];
				end
				recovery_pkg::LIMIT_OFS:
					cfg_reg.retry_limit <= req.wdata[recovery_pkg::RETRY_W-1:0];
				recovery_pkg::MASK_OFS:
					cfg_reg.fault_select_mask <= req.wdata[recovery_pkg::CAUSE_W-1:0];
				recovery_pkg::FIRST_OFS:
					cfg_reg.first_wait_seconds <= req.wdata[recovery_pkg::SEC_W-1:0];
				recovery_pkg::LATER_OFS:
					cfg_reg.later_wait_seconds <= req.wdata[recovery_pkg::SEC_W-1:0];
				default:
				begin
				end
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe; unmapped reads return zero.
	always_comb
	begin
		rdata_next = '0;
		unique case (req.addr)
			recovery_pkg::CTRL_OFS:
			begin
				rdata_next[recovery_pkg::CTRL_EN_BIT] = cfg_reg.recovery_enable;
				rdata_next[recovery_pkg::CTRL_POL_LSB +: 2] = cfg_reg.recovery_policy;
			end
			recovery_pkg::LIMIT_OFS:
				rdata_next[recovery_pkg::RETRY_W-1:0] = cfg_reg.retry_limit;
			recovery_pkg::MASK_OFS:
				rdata_next[recovery_pkg::CAUSE_W-1:0] = cfg_reg.fault_select_mask;
			recovery_pkg::FIRST_OFS:
				rdata_next[recovery_pkg::SEC_W-1:0] = cfg_reg.first_wait_seconds;
			recovery_pkg::LATER_OFS:
				rdata_next[recovery_pkg::SEC_W-1:0] = cfg_reg.later_wait_seconds;
			recovery_pkg::STATE_OFS:
			begin
				rdata_next[recovery_pkg::ST_ACTIVE_BIT] = recovery_active;
				rdata_next[recovery_pkg::ST_PENDING_BIT] = restart_pending;
				rdata_next[recovery_pkg::ST_DISABLED_BIT] = self_disabled;
				rdata_next[recovery_pkg::ST_RETRY_LSB +: recovery_pkg::RETRY_W] = retries_left_reg;
				rdata_next[recovery_pkg::ST_TIME_LSB +: recovery_pkg::SEC_W] = timer_reg;
			end
			recovery_pkg::ATTEMPT_OFS:
				rdata_next[recovery_pkg::ATT_W-1:0] = attempts_reg;
			recovery_pkg::IRQ_STAT_OFS:
				rdata_next[recovery_pkg::EV_W-1:0] = irq_stat_reg;
			recovery_pkg::IRQ_MASK_OFS:
				rdata_next[recovery_pkg::EV_W-1:0] = irq_mask_reg;
			default:
				rdata_next = '0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (req.rd)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= '0;
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// A new event in the same cycle as a write-one-to-clear keeps its bit set.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			irq <= 1'b0;
		end
		else
		begin
			if (req.wr && req.addr == recovery_pkg::IRQ_STAT_OFS)
				irq_stat_reg <= (irq_stat_reg & ~req.wdata[recovery_pkg::EV_W-1:0]) | ev_set;
			else
				irq_stat_reg <= irq_stat_reg | ev_set;
			if (req.wr && req.addr == recovery_pkg::IRQ_MASK_OFS)
				irq_mask_reg <= req.wdata[recovery_pkg::EV_W-1:0];
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// ----------------------------------------------------------------
	// Second tick
	// ----------------------------------------------------------------
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
	logic [31:0] tick_cnt_reg;
	logic tick;
	logic tick_restart;

	// The divider restarts when a delay is loaded so every counted second is whole.
	always_ff @(posedge clk)
	begin
		if (!rst_n || tick_restart)
		begin
			tick_cnt_reg <= '0;
			tick <= 1'b0;
		end
		else if (tick_cnt_reg == TICK_LAST)
		begin
			tick_cnt_reg <= '0;
			tick <= 1'b1;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Recovery sequencing
	// ----------------------------------------------------------------
	logic sources_clear;
	logic selected_trip;
	logic enable_rise;
	logic restart_wanted;
	logic run_ok;
	logic first_attempt;

	assign sources_clear = ~|trip_sources;
	assign selected_trip = trip_event && |(trip_cause & cfg_reg.fault_select_mask);
	assign enable_rise = cfg_reg.recovery_enable && !enable_prev_reg;
	assign first_attempt = retries_left_reg == cfg_reg.retry_limit;
	assign run_ok = run_request && !run_lost_reg;

	always_comb
	begin
		unique case (cfg_reg.recovery_policy)
			recovery_pkg::RESUME_IF_WAS_RUNNING:
				restart_wanted = was_running_reg && run_ok;
			recovery_pkg::LAUNCH_ON_RUN_REQUEST:
				restart_wanted = run_request;
			default:
				restart_wanted = 1'b0;
		endcase
	end

	assign tick_restart = state_reg == recovery_pkg::ST_WAIT_CLEAR && sources_clear
		&& restart_wanted;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= recovery_pkg::ST_IDLE;
			timer_reg <= '0;
			trip_clear <= 1'b0;
			motor_start <= 1'b0;
			ev_set <= '0;
		end
		else
		begin
			trip_clear <= 1'b0;
			motor_start <= 1'b0;
			ev_set <= '0;
			if (!cfg_reg.recovery_enable || manual_trip_reset)
			begin
				state_reg <= recovery_pkg::ST_IDLE;
				timer_reg <= '0;
			end
			else
			begin
				unique case (state_reg)
					recovery_pkg::ST_IDLE:
						if (selected_trip)
						begin
							if (retries_left_reg == '0
								&& cfg_reg.recovery_policy != recovery_pkg::CLEAR_ONLY_POLICY)
							begin
								state_reg <= recovery_pkg::ST_DISABLED;
								ev_set[recovery_pkg::EV_DISABLED] <= 1'b1;
							end
							else
								state_reg <= recovery_pkg::ST_WAIT_CLEAR;
						end
					recovery_pkg::ST_WAIT_CLEAR:
						if (sources_clear)
						begin
							if (restart_wanted)
							begin
								state_reg <= recovery_pkg::ST_DELAY;
								timer_reg <= first_attempt ? cfg_reg.first_wait_seconds
									: cfg_reg.later_wait_seconds;
							end
							else
							begin
								state_reg <= recovery_pkg::ST_IDLE;
								trip_clear <= 1'b1;
								ev_set[recovery_pkg::EV_CLEARED] <= 1'b1;
							end
						end
					recovery_pkg::ST_DELAY:
						if (!sources_clear)
							state_reg <= recovery_pkg::ST_WAIT_CLEAR;
						else if (timer_reg == '0)
						begin
							state_reg <= recovery_pkg::ST_IDLE;
							trip_clear <= 1'b1;
							ev_set[recovery_pkg::EV_CLEARED] <= 1'b1;
							if (restart_wanted)
							begin
								motor_start <= 1'b1;
								ev_set[recovery_pkg::EV_RESTART] <= 1'b1;
							end
						end
						else if (tick)
							timer_reg <= timer_reg - 16'h0001;
					recovery_pkg::ST_DISABLED:
						state_reg <= recovery_pkg::ST_DISABLED;
				endcase
			end
		end
	end

	// Run history since the trip; resume_if_was_running drops to clear-only once run is lost.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			was_running_reg <= 1'b0;
			run_lost_reg <= 1'b0;
			enable_prev_reg <= 1'b0;
		end
		else
		begin
			enable_prev_reg <= cfg_reg.recovery_enable;
			if (state_reg == recovery_pkg::ST_IDLE && selected_trip)
			begin
				was_running_reg <= motor_running;
				run_lost_reg <= !run_request;
			end
			else if (!run_request)
				run_lost_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Retry accounting
	// ----------------------------------------------------------------
	localparam logic [8:0] REFRESH_LAST = 9'(recovery_pkg::REFRESH_SECONDS);
	logic [8:0] trip_free_reg;
	logic attempt_now;

	assign attempt_now = state_reg == recovery_pkg::ST_DELAY && cfg_reg.recovery_enable
		&& !manual_trip_reset && sources_clear && timer_reg == '0 && restart_wanted;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			retries_left_reg <= recovery_pkg::LIMIT_RST;
			attempts_reg <= '0;
			trip_free_reg <= '0;
		end
		else
		begin
			if (state_reg != recovery_pkg::ST_IDLE || !sources_clear)
				trip_free_reg <= '0;
			else if (tick && trip_free_reg != REFRESH_LAST)
				trip_free_reg <= trip_free_reg + 9'h001;
			if (manual_trip_reset || enable_rise
				|| (trip_free_reg == REFRESH_LAST && state_reg == recovery_pkg::ST_IDLE))
				retries_left_reg <= cfg_reg.retry_limit;
			else if (attempt_now && retries_left_reg != '0)
				retries_left_reg <= retries_left_reg - 8'h01;
			if (attempt_now)
				attempts_reg <= attempts_reg + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			recovery_active <= 1'b0;
			restart_pending <= 1'b0;
			self_disabled <= 1'b0;
		end
		else
		begin
			recovery_active <= state_reg == recovery_pkg::ST_WAIT_CLEAR
				|| state_reg == recovery_pkg::ST_DELAY;
			restart_pending <= state_reg == recovery_pkg::ST_DELAY;
			self_disabled <= state_reg == recovery_pkg::ST_DISABLED;
		end
	end

endmodule

`default_nettype wire

// ---- design/recovery_pkg.sv ----
// Package with the shared constants, offsets and types of the fault recovery unit.
package recovery_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CAUSE_W = 16;
	localparam int SRC_W = 8;
	localparam int RETRY_W = 8;
	localparam int SEC_W = 16;
	localparam int ATT_W = 16;
	localparam int EV_W = 3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int SECOND_NS = 1000000000;
	localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	localparam int REFRESH_MINUTES = 5;
	localparam int REFRESH_SECONDS = REFRESH_MINUTES * 60;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] LIMIT_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] MASK_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] FIRST_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] LATER_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] STATE_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] ATTEMPT_OFS = 8'h18;
	localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h1C;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_POL_LSB = 1;
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_PENDING_BIT = 1;
	localparam int ST_DISABLED_BIT = 2;
	localparam int ST_RETRY_LSB = 8;
	localparam int ST_TIME_LSB = 16;
	localparam int EV_CLEARED = 0;
	localparam int EV_RESTART = 1;
	localparam int EV_DISABLED = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [RETRY_W-1:0] LIMIT_RST = 8'h05;
	localparam logic [CAUSE_W-1:0] MASK_RST = 16'h0000;
	localparam logic [SEC_W-1:0] FIRST_RST = 16'h000A;
	localparam logic [SEC_W-1:0] LATER_RST = 16'h000A;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CLEAR_ONLY_POLICY = 2'h0,
		RESUME_IF_WAS_RUNNING = 2'h1,
		LAUNCH_ON_RUN_REQUEST = 2'h2
	} recovery_policy_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT_CLEAR = 4'h2,
		ST_DELAY = 4'h4,
		ST_DISABLED = 4'h8
	} unit_state_t;

	typedef struct packed {
		logic recovery_enable;
		logic [1:0] recovery_policy;
		logic [RETRY_W-1:0] retry_limit;
		logic [CAUSE_W-1:0] fault_select_mask;
		logic [SEC_W-1:0] first_wait_seconds;
		logic [SEC_W-1:0] later_wait_seconds;
	} settings_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

endpackage

// ---- sim/fault_recovery_unit_sva.sv ----
// Concurrent checks on the ports of the fault recovery unit.
`timescale 1ns/1ns
`default_nettype none
module fault_recovery_unit_sva #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic [recovery_pkg::ADDR_W-1:0] reg_addr, // Register address.
	input wire logic [recovery_pkg::DATA_W-1:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	input wire logic [recovery_pkg::DATA_W-1:0] reg_rdata, // Read data.
	input wire logic [recovery_pkg::SRC_W-1:0] trip_sources, // Active trip sources.
	input wire logic manual_trip_reset, // Trip reset by other means.
	input wire logic trip_clear, // Trip reset pulse.
	input wire logic motor_start, // Restart pulse.
	input wire logic recovery_active, // Handling a trip.
	input wire logic restart_pending, // Delay running.
	input wire logic self_disabled // Retries exhausted.
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_START_WITH_CLEAR: assert property (motor_start |-> trip_clear)
		else $error("motor start without trip clear");
	AST_CLEAR_PULSE: assert property (trip_clear |=> !trip_clear)
		else $error("trip clear longer than one cycle");
	AST_CLEAR_NO_SOURCE: assert property (trip_clear |-> $past(trip_sources) == '0)
		else $error("trip cleared while a source was active");
	AST_CLEAR_WHEN_ACTIVE: assert property (trip_clear |-> recovery_active)
		else $error("trip clear outside recovery");
	AST_PENDING_ACTIVE: assert property (restart_pending |-> recovery_active)
		else $error("restart pending while not active");
	AST_DELAY_START: assert property ($rose(restart_pending) |-> $past(trip_sources) == '0)
		else $error("delay started with a source active");
	AST_DISABLED_QUIET: assert property (self_disabled |-> !recovery_active && !trip_clear)
		else $error("self disabled unit still acting");
	AST_ENABLE_OFF: assert property (reg_wr && reg_addr == recovery_pkg::CTRL_OFS
		&& !reg_wdata[recovery_pkg::CTRL_EN_BIT] |-> ##3 !recovery_active && !self_disabled)
		else $error("unit not idle after disable");
	AST_MANUAL_EXIT: assert property (manual_trip_reset |-> ##2 !recovery_active && !self_disabled)
		else $error("unit not idle after manual trip reset");
	AST_RDATA_SLOT: assert property (reg_rdata != '0 |-> $past(reg_rd))
		else $error("read data outside its slot");

	COV_RESTART: cover property (motor_start);
	COV_CLEAR_ONLY: cover property (trip_clear && !motor_start);
	COV_DISABLE: cover property ($rose(self_disabled));
endmodule

bind fault_recovery_unit fault_recovery_unit_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_i (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .trip_sources(trip_sources),
	.manual_trip_reset(manual_trip_reset), .trip_clear(trip_clear), .motor_start(motor_start),
	.recovery_active(recovery_active), .restart_pending(restart_pending),
	.self_disabled(self_disabled));
`default_nettype wire

// ---- sim/drive_trip_model.sv ----
// Model of the drive's trip sources and run sequencing logic.
`timescale 1ns/1ns
`default_nettype none
module drive_trip_model (
	input wire logic clk, // System clock.
	output logic trip_event, // Trip pulse.
	output logic [recovery_pkg::CAUSE_W-1:0] trip_cause, // Trip cause bits.
	output logic [recovery_pkg::SRC_W-1:0] trip_sources, // Active sources.
	output logic motor_running, // Motor running.
	output logic run_request, // Run request.
	output logic manual_trip_reset // Trip reset by other means.
);
	initial
	begin
		trip_event = 1'b0;
		trip_cause = '0;
		trip_sources = '0;
		motor_running = 1'b0;
		run_request = 1'b0;
		manual_trip_reset = 1'b0;
	end

	// The motor coasts to a stop at a trip; cause lines are not held after the pulse.
	task automatic trip(input logic [15:0] cause, input logic [7:0] src, input logic running);
		@(posedge clk);
		trip_event <= 1'b1;
		trip_cause <= cause;
		trip_sources <= src;
		motor_running <= running;
		@(posedge clk);
		trip_event <= 1'b0;
		trip_cause <= ~cause;
		motor_running <= 1'b0;
	endtask

	task automatic release_sources();
		@(posedge clk);
		trip_sources <= '0;
	endtask

	task automatic set_run(input logic run);
		@(posedge clk);
		run_request <= run;
	endtask

	task automatic trip_reset();
		@(posedge clk);
		manual_trip_reset <= 1'b1;
		@(posedge clk);
		manual_trip_reset <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- sim/fault_recovery_unit_tb_top.sv ----
// Self-checking testbench of the fault recovery unit.
`timescale 1ns/1ns
`default_nettype none
module fault_recovery_unit_tb_top;
	localparam int TICKS = 10;
	localparam logic [15:0] SEL = 16'h00F0;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_d = 1'b0;
	logic [31:0] reg_rdata;
	logic trip_event, motor_running, run_request, manual_trip_reset;
	logic [15:0] trip_cause;
	logic [7:0] trip_sources;
	logic trip_clear, motor_start, recovery_active, restart_pending, self_disabled, irq;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic start_q[$];
	logic [7:0] adr_t[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h24};
	logic [31:0] val_t[7] = '{32'h0, 32'h5, 32'h0, 32'hA, 32'hA, 32'h0, 32'h0};
	int seed = 35;
	int mismatches = 0;
	int num_checks = 0;

	always #2 clk = ~clk;

	fault_recovery_unit #(.TICK_CYCLES(TICKS)) fault_recovery_unit_i (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .trip_event(trip_event), .trip_cause(trip_cause),
		.trip_sources(trip_sources), .motor_running(motor_running), .run_request(run_request),
		.manual_trip_reset(manual_trip_reset), .trip_clear(trip_clear), .motor_start(motor_start),
		.recovery_active(recovery_active), .restart_pending(restart_pending),
		.self_disabled(self_disabled), .irq(irq));

	drive_trip_model drive_trip_model_i (.clk(clk), .trip_event(trip_event),
		.trip_cause(trip_cause), .trip_sources(trip_sources), .motor_running(motor_running),
		.run_request(run_request), .manual_trip_reset(manual_trip_reset));

	// ----------------------------------------------------------------
	// Checking
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Any trip clear without a pending note compares against an impossible value.
	always @(posedge clk)
	begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1)
			check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
		if (trip_clear === 1'b1)
			check({31'h0, motor_start}, start_q.size() > 0 ? {31'h0, start_q.pop_front()} : '1);
	end

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		@(posedge clk);
		exp_q.push_back(e);
		msk_q.push_back(m);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	task automatic rd_state(input logic [31:0] e);
		rd(recovery_pkg::STATE_OFS, e, 32'h0000FF07);
	endtask

	// Counts cycles from the release of the sources to the trip clear pulse.
	task automatic wait_clear(input int lo, input int hi);
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		while (trip_clear !== 1'b1 && n < hi + 40)
		begin
			@(posedge clk);
			seen = seen | (restart_pending === 1'b1);
			n++;
		end
		check({31'h0, n >= lo && n <= hi}, 32'h1);
		check({31'h0, seen}, {31'h0, lo > 4});
	endtask

	task automatic trip_sel(input logic running);
		logic [15:0] c;
		c = SEL & 16'($random(seed));
		drive_trip_model_i.trip(c == '0 ? SEL : c, 8'($random(seed)) | 8'h01, running);
	endtask

	task automatic recover(input logic running, input logic start, input int lo, input int hi);
		start_q.push_back(start);
		trip_sel(running);
		repeat (3) @(posedge clk);
		check({31'h0, recovery_active}, 32'h1);
		drive_trip_model_i.release_sources();
		wait_clear(lo, hi);
	endtask

	initial
	begin
		#(4 * 20000);
		mismatches++;
		conclude();
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd(adr_t[i], val_t[i]);
		rd_state(32'h0500);
		wr(recovery_pkg::ATTEMPT_OFS, 32'h1234);
		rd(recovery_pkg::ATTEMPT_OFS, 32'h0);
		wr(recovery_pkg::LIMIT_OFS, 32'h3);
		wr(recovery_pkg::MASK_OFS, {16'h0, SEL});
		wr(recovery_pkg::FIRST_OFS, 32'h2);
		wr(recovery_pkg::LATER_OFS, 32'h1);
		wr(recovery_pkg::IRQ_MASK_OFS, 32'h7);
		wr(recovery_pkg::CTRL_OFS, 32'h4);
		drive_trip_model_i.set_run(1'b1);
		trip_sel(1'b1);
		drive_trip_model_i.release_sources();
		repeat (30) @(posedge clk);
		rd_state(32'h0500);
		wr(recovery_pkg::CTRL_OFS, 32'h5);
		drive_trip_model_i.trip(16'h0001, 8'h01, 1'b1);
		repeat (3) @(posedge clk);
		rd_state(32'h0300);
		drive_trip_model_i.release_sources();
		wr(recovery_pkg::CTRL_OFS, 32'h1);
		recover(1'b1, 1'b0, 1, 4);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		wr(recovery_pkg::IRQ_STAT_OFS, 32'h7);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		rd_state(32'h0300);
		wr(recovery_pkg::CTRL_OFS, 32'h5);
		recover(1'b0, 1'b1, 2 * TICKS, 2 * TICKS + 5);
		recover(1'b0, 1'b1, TICKS, TICKS + 5);
		rd_state(32'h0100);
		rd(recovery_pkg::ATTEMPT_OFS, 32'h2);
		wr(recovery_pkg::CTRL_OFS, 32'h3);
		recover(1'b0, 1'b0, 1, 4);
		start_q.push_back(1'b0);
		trip_sel(1'b1);
		drive_trip_model_i.set_run(1'b0);
		drive_trip_model_i.set_run(1'b1);
		drive_trip_model_i.release_sources();
		wait_clear(1, 4);
		recover(1'b1, 1'b1, TICKS, TICKS + 5);
		wr(recovery_pkg::IRQ_MASK_OFS, 32'h4);
		wr(recovery_pkg::IRQ_STAT_OFS, 32'h7);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		trip_sel(1'b1);
		repeat (4) @(posedge clk);
		check({31'h0, self_disabled, irq}, 32'h3);
		drive_trip_model_i.release_sources();
		repeat (30) @(posedge clk);
		rd_state(32'h0004);
		drive_trip_model_i.trip_reset();
		repeat (3) @(posedge clk);
		rd_state(32'h0300);
		recover(1'b0, 1'b0, 1, 4);
		wr(recovery_pkg::CTRL_OFS, 32'h5);
		recover(1'b0, 1'b1, 2 * TICKS, 2 * TICKS + 5);
		rd_state(32'h0200);
		repeat (300 * TICKS + 30) @(posedge clk);
		rd_state(32'h0300);
		repeat (3) @(posedge clk);
		conclude();
	end
endmodule
`default_nettype wire
